// [shared/ocd_pkg.sv]
// Package of opcodes, mode nibbles, cycle counts and carrier types for the opcode decoder tail.
package ocd_pkg;

  // Opcodes handled in full by this block.
  localparam logic [7:0] OP_TEST_PAGE0 = 8'h3D;
  localparam logic [7:0] OP_TEST_ACC   = 8'h4D;
  localparam logic [7:0] OP_TEST_INDEX = 8'h5D;
  localparam logic [7:0] OP_TEST_IXB   = 8'h6D;
  localparam logic [7:0] OP_TEST_IXZ   = 8'h7D;
  localparam logic [7:0] OP_IDX_TO_ACC = 8'h9F;
  localparam logic [7:0] OP_WAIT_INT   = 8'h8F;

  // Total cycle counts, opcode fetch included.
  localparam logic [3:0] CYC_TEST_PAGE0 = 4'h4;
  localparam logic [3:0] CYC_TEST_ACC   = 4'h3;
  localparam logic [3:0] CYC_TEST_INDEX = 4'h3;
  localparam logic [3:0] CYC_TEST_IXB   = 4'h5;
  localparam logic [3:0] CYC_TEST_IXZ   = 4'h4;
  localparam logic [3:0] CYC_IDX_TO_ACC = 4'h2;
  localparam logic [3:0] CYC_WAIT_INT   = 4'h2;
  localparam logic [3:0] CYC_DEFAULT    = 4'h2;

  // Flag register bit positions.
  localparam int FLG_C = 0;
  localparam int FLG_Z = 1;
  localparam int FLG_N = 2;
  localparam int FLG_I = 3;
  localparam int FLG_H = 4;

  // Reset values.
  localparam logic [15:0] RST_PC    = 16'h0000;
  localparam logic [7:0]  RST_BYTE  = 8'h00;
  localparam logic [4:0]  RST_FLAGS = 5'h08;

  // Addressing modes selected by the opcode high nibble.
  typedef enum logic [3:0] {
    MODE_BIT_PAGE0,
    MODE_RELATIVE,
    MODE_PAGE0,
    MODE_ACC,
    MODE_INDEX,
    MODE_INHERENT,
    MODE_LITERAL,
    MODE_LONG,
    MODE_IX_WORD,
    MODE_IX_BYTE,
    MODE_IX_ZERO
  } ocd_mode_type;

  // Decoded summary of one opcode.
  typedef struct packed {
    ocd_mode_type mode;
    logic [1:0]   operand_count;
    logic         bit_branch;
  } ocd_decode_type;

  // Result presented to the core after an instruction ends.
  typedef struct packed {
    logic [15:0] eff_addr;
    logic [15:0] branch_target;
    logic        branch_taken;
    logic [7:0]  opcode;
  } ocd_result_type;

endpackage

// [logic/ocd_mode_map.sv]
// Opcode high-nibble to addressing-mode and operand-count lookup.
`timescale 1ns/1ps
module ocd_mode_map
  import ocd_pkg::*;
(
  // Opcode in.
  input  wire logic [7:0]     opcode_i,
  // Decoded mode out.
  output ocd_decode_type      decode_o
);

  always_comb begin
    decode_o = '{mode: MODE_INHERENT, operand_count: 2'd0, bit_branch: 1'b0};
    unique case (opcode_i[7:4])
      4'h0: decode_o = '{mode: MODE_BIT_PAGE0, operand_count: 2'd2, bit_branch: 1'b1};
      4'h1: decode_o = '{mode: MODE_BIT_PAGE0, operand_count: 2'd1, bit_branch: 1'b0};
      4'h2: decode_o = '{mode: MODE_RELATIVE, operand_count: 2'd1, bit_branch: 1'b0};
      4'h3: decode_o = '{mode: MODE_PAGE0, operand_count: 2'd1, bit_branch: 1'b0};
      4'h4: decode_o = '{mode: MODE_ACC, operand_count: 2'd0, bit_branch: 1'b0};
      4'h5: decode_o = '{mode: MODE_INDEX, operand_count: 2'd0, bit_branch: 1'b0};
      4'h6: decode_o = '{mode: MODE_IX_BYTE, operand_count: 2'd1, bit_branch: 1'b0};
      4'h7: decode_o = '{mode: MODE_IX_ZERO, operand_count: 2'd0, bit_branch: 1'b0};
      4'h8: decode_o = '{mode: MODE_INHERENT, operand_count: 2'd0, bit_branch: 1'b0};
      4'h9: decode_o = '{mode: MODE_INHERENT, operand_count: 2'd0, bit_branch: 1'b0};
      4'hA: decode_o = '{mode: MODE_LITERAL, operand_count: 2'd1, bit_branch: 1'b0};
      4'hB: decode_o = '{mode: MODE_PAGE0, operand_count: 2'd1, bit_branch: 1'b0};
      4'hC: decode_o = '{mode: MODE_LONG, operand_count: 2'd2, bit_branch: 1'b0};
      4'hD: decode_o = '{mode: MODE_IX_WORD, operand_count: 2'd2, bit_branch: 1'b0};
      4'hE: decode_o = '{mode: MODE_IX_BYTE, operand_count: 2'd1, bit_branch: 1'b0};
      4'hF: decode_o = '{mode: MODE_IX_ZERO, operand_count: 2'd0, bit_branch: 1'b0};
    endcase
  end

endmodule

// [logic/ocd_decoder.sv]
// Opcode decoder tail: fetch sequencing, addressing and the test, transfer and wait instructions.
`timescale 1ns/1ps
module ocd_decoder
  import ocd_pkg::*;
(
  // Clock and reset.
  input  wire logic                clk_i,
  input  wire logic                sys_rst_i,
  // Program memory byte stream.
  input  wire logic [7:0]          mem_data_i,
  input  wire logic                mem_valid_i,
  output logic                     mem_ready_o,
  output logic [15:0]              pc_o,
  // Operand byte at the effective address, supplied by the core.
  input  wire logic [7:0]          data_byte_i,
  // Interrupt wake request, from core logic on this clock.
  input  wire logic                irq_i,
  // Branch condition from the core for relative branches.
  input  wire logic                branch_cond_i,
  // Core registers.
  output logic [7:0]               acc_o,
  output logic [7:0]               index_o,
  output logic [4:0]               flags_o,
  output logic                     clock_halt_o,
  // Per-instruction result.
  output ocd_result_type           result_o,
  output logic                     done_o
);

  typedef enum logic [2:0] {
    ST_OPCODE,
    ST_OPER1,
    ST_OPER2,
    ST_EXEC,
    ST_HALT
  } ocd_state_type;

  ocd_state_type   state;
  ocd_decode_type  dec;
  logic [7:0]      opcode;
  logic [7:0]      oper1;
  logic [7:0]      oper2;
  logic [3:0]      cyc_cnt;
  logic [3:0]      cyc_total;
  logic [15:0]     pc;
  logic [7:0]      acc;
  logic [7:0]      index;
  logic [4:0]      flags;
  logic            halt;
  logic            fetch;
  logic [15:0]     next_eff_addr;
  logic [15:0]     next_target;
  logic            next_taken;
  logic [7:0]      test_value;
  logic [15:0]     disp_ext;

  // Mode lookup for the latched opcode.
  ocd_mode_map u_mode_map (
    .opcode_i (opcode),
    .decode_o (dec)
  );

  // A byte is consumed only in the fetch states.
  assign fetch       = mem_valid_i && (state == ST_OPCODE || state == ST_OPER1 || state == ST_OPER2);
  assign mem_ready_o = (state == ST_OPCODE || state == ST_OPER1 || state == ST_OPER2);

  // Cycle budget per opcode; unknown ones run the minimum.
  always_comb begin
    unique case (opcode)
      OP_TEST_PAGE0: cyc_total = CYC_TEST_PAGE0;
      OP_TEST_ACC:   cyc_total = CYC_TEST_ACC;
      OP_TEST_INDEX: cyc_total = CYC_TEST_INDEX;
      OP_TEST_IXB:   cyc_total = CYC_TEST_IXB;
      OP_TEST_IXZ:   cyc_total = CYC_TEST_IXZ;
      OP_IDX_TO_ACC: cyc_total = CYC_IDX_TO_ACC;
      OP_WAIT_INT:   cyc_total = CYC_WAIT_INT;
      default:       cyc_total = CYC_DEFAULT;
    endcase
  end

  // Address arithmetic. The displacement is sign-extended; the PC already points past the operands.
  always_comb begin
    next_eff_addr = 16'h0000;
    disp_ext      = {{8{oper1[7]}}, oper1};
    next_taken    = 1'b0;
    next_target   = pc;
    unique case (dec.mode)
      MODE_LONG:      next_eff_addr = {oper1, oper2};
      MODE_IX_WORD:   next_eff_addr = 16'({oper1, oper2} + {8'h00, index});
      MODE_IX_BYTE:   next_eff_addr = 16'({8'h00, oper1} + {8'h00, index});
      MODE_IX_ZERO:   next_eff_addr = {8'h00, index};
      MODE_PAGE0:     next_eff_addr = {8'h00, oper1};
      MODE_BIT_PAGE0: next_eff_addr = {8'h00, oper1};
      default:        next_eff_addr = 16'h0000;
    endcase
    if (dec.bit_branch) begin
      disp_ext    = {{8{oper2[7]}}, oper2};
      next_taken  = data_byte_i[opcode[3:1]] ^ opcode[0];
      next_target = 16'(pc + disp_ext);
    end
    else if (dec.mode == MODE_RELATIVE) begin
      next_taken  = branch_cond_i;
      next_target = 16'(pc + disp_ext);
    end
  end

  // Operand seen by the test: accumulator, index or the memory byte.
  always_comb begin
    unique case (dec.mode)
      MODE_ACC:   test_value = acc;
      MODE_INDEX: test_value = index;
      default:    test_value = data_byte_i;
    endcase
  end

  // Sequencer: opcode, up to two operands, then the remaining execute cycles.
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      state   <= ST_OPCODE;
      opcode  <= RST_BYTE;
      oper1   <= RST_BYTE;
      oper2   <= RST_BYTE;
      cyc_cnt <= 4'h0;
    end else begin
      unique case (state)
        ST_OPCODE: if (fetch) begin
          opcode  <= mem_data_i;
          cyc_cnt <= 4'h1;
          state   <= ST_EXEC;
        end
        ST_OPER1: if (fetch) begin
          oper1   <= mem_data_i;
          cyc_cnt <= cyc_cnt + 4'h1;
          state   <= (dec.operand_count == 2'd2) ? ST_OPER2 : ST_EXEC;
        end
        ST_OPER2: if (fetch) begin
          oper2   <= mem_data_i;
          cyc_cnt <= cyc_cnt + 4'h1;
          state   <= ST_EXEC;
        end
        ST_EXEC: begin
          if (cyc_cnt == 4'h1 && dec.operand_count != 2'd0) begin
            // The decode cycle before the operand fetch counts toward the budget.
            cyc_cnt <= cyc_cnt + 4'h1;
            state   <= ST_OPER1;
          end else if (cyc_cnt + 4'h1 >= cyc_total) begin
            cyc_cnt <= 4'h0;
            state   <= (opcode == OP_WAIT_INT) ? ST_HALT : ST_OPCODE;
          end else begin
            cyc_cnt <= cyc_cnt + 4'h1;
          end
        end
        ST_HALT: if (irq_i) begin
          state <= ST_OPCODE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      pc <= RST_PC;
    end else if (fetch) begin
      pc <= pc + 16'h0001;
    end
  end

  // End of instruction: the done pulse and the register effects land together.
  logic last_exec;
  assign last_exec = (state == ST_EXEC) && !(cyc_cnt == 4'h1 && dec.operand_count != 2'd0)
                     && (cyc_cnt + 4'h1 >= cyc_total);

  // Accumulator and index updates; only the transfer writes here in this block.
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      acc   <= RST_BYTE;
      index <= RST_BYTE;
    end else if (last_exec && opcode == OP_IDX_TO_ACC) begin
      acc <= index;
    end
  end

  // Flag updates. Transfer leaves all flags as they were.
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      flags <= RST_FLAGS;
    end else if (last_exec) begin
      if (opcode[3:0] == 4'hD && opcode[7:4] >= 4'h3 && opcode[7:4] <= 4'h7) begin
        flags[FLG_N] <= test_value[7];
        flags[FLG_Z] <= (test_value == 8'h00);
      end else if (opcode == OP_WAIT_INT) begin
        flags[FLG_I] <= 1'b0;
      end
    end
  end

  // Clock halt request stands from the end of the wait until the wake.
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      halt <= 1'b0;
    end else if (last_exec && opcode == OP_WAIT_INT) begin
      halt <= 1'b1;
    end else if (irq_i) begin
      halt <= 1'b0;
    end
  end

  // Registered result, held until the next instruction ends.
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      result_o <= '0;
      done_o   <= 1'b0;
    end else begin
      done_o <= last_exec;
      if (last_exec) begin
        result_o <= '{eff_addr: next_eff_addr, branch_target: next_target,
                      branch_taken: next_taken, opcode: opcode};
      end
    end
  end

  assign pc_o         = pc;
  assign acc_o        = acc;
  assign index_o      = index;
  assign flags_o      = flags;
  assign clock_halt_o = halt;

endmodule

// [bench/ocd_checker.sv]
// Concurrent checks on the opcode decoder ports, bound to its top module.
`timescale 1ns/1ps
module ocd_checker
  import ocd_pkg::*;
(
  // Clock and reset.
  input wire logic           clk_i,
  input wire logic           sys_rst_i,
  // Watched ports.
  input wire logic           mem_valid_i,
  input wire logic           mem_ready_o,
  input wire logic [15:0]    pc_o,
  input wire logic           irq_i,
  input wire logic [7:0]     acc_o,
  input wire logic [7:0]     index_o,
  input wire logic [4:0]     flags_o,
  input wire logic           clock_halt_o,
  input wire ocd_result_type result_o,
  input wire logic           done_o
);
  // One clock domain, so clocking and reset gating are declared once.
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  wire [7:0] op = result_o.opcode;
  property p_pc_step; mem_valid_i && mem_ready_o |=> pc_o == $past(pc_o) + 16'h0001; endproperty
  a_pc_step: assert property (p_pc_step) else $error("pc did not step past a taken byte");
  property p_done_pulse; done_o |=> !done_o; endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("done held too long");
  property p_xfer; done_o && op == OP_IDX_TO_ACC |-> acc_o == index_o && flags_o == $past(flags_o, 2); endproperty
  a_xfer: assert property (p_xfer) else $error("index transfer wrong");
  property p_wait; done_o && op == OP_WAIT_INT && !irq_i |-> clock_halt_o && !flags_o[FLG_I]; endproperty
  a_wait: assert property (p_wait) else $error("wait did not halt or unmask");
  property p_halt_ready; clock_halt_o |-> !mem_ready_o; endproperty
  a_halt_ready: assert property (p_halt_ready) else $error("fetch while halted");
  property p_wake; clock_halt_o && irq_i |-> ##[1:3] !clock_halt_o; endproperty
  a_wake: assert property (p_wake) else $error("no wake after interrupt");
  property p_test_keep;
    done_o && op[3:0] == 4'hD && op[7:4] inside {[4'h3:4'h7]} |->
      $stable(flags_o[FLG_C]) && flags_o[FLG_H] == $past(flags_o[FLG_H], 2);
  endproperty
  a_test_keep: assert property (p_test_keep) else $error("test changed carry or half carry");
  property p_test_acc; done_o && op == OP_TEST_ACC |-> flags_o[FLG_Z] == (acc_o == 8'h00) && flags_o[FLG_N] == acc_o[7]; endproperty
  a_test_acc: assert property (p_test_acc) else $error("accumulator test flags wrong");
  property p_ix_zero; done_o && op[7:4] inside {4'h7, 4'hF} |-> result_o.eff_addr == {8'h00, index_o}; endproperty
  a_ix_zero: assert property (p_ix_zero) else $error("zero offset address wrong");
  // Main scenarios reached.
  c_wake: cover property (clock_halt_o && irq_i);
  c_xfer: cover property (done_o && op == OP_IDX_TO_ACC);
  c_ixb: cover property (done_o && op == OP_TEST_IXB);
endmodule
bind ocd_decoder ocd_checker i_chk (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .mem_valid_i(mem_valid_i),
  .mem_ready_o(mem_ready_o), .pc_o(pc_o), .irq_i(irq_i), .acc_o(acc_o), .index_o(index_o),
  .flags_o(flags_o), .clock_halt_o(clock_halt_o), .result_o(result_o), .done_o(done_o));

// [bench/ocd_prog_mem.sv]
// Program memory model feeding opcode and operand bytes to the decoder.
`timescale 1ns/1ps
module ocd_prog_mem (
  // Clock.
  input  wire logic        clk_i,
  // Fetch address and stall request.
  input  wire logic [15:0] pc_i,
  input  wire logic        stall_i,
  // Byte stream.
  output logic [7:0]       data_o,
  output logic             valid_o
);
  logic [7:0] mem [0:255];
  logic       tog = 1'b0;
  // Stalls drop valid every other cycle, a slow memory.
  always_ff @(posedge clk_i) begin
    tog <= !tog;
  end
  // bytes in stored order
  // An absent byte shows the inverse, so stale data cannot pass for a fetch.
  assign valid_o = !(stall_i && tog);
  assign data_o  = valid_o ? mem[pc_i[7:0]] : ~mem[pc_i[7:0]];
endmodule

// [bench/tb.sv]
// Self-checking testbench running a short program through the decoder.
`timescale 1ns/1ps
module tb
  import ocd_pkg::*;
;
  logic           clk_i = 1'b0;
  logic           sys_rst_i = 1'b1;
  logic [7:0]     mem_data_i, data_byte_i = 8'h00;
  logic           mem_valid_i, mem_ready_o, irq_i = 1'b0, branch_cond_i = 1'b0, stall = 1'b0;
  logic [15:0]    pc_o;
  logic [7:0]     acc_o, index_o;
  logic [4:0]     flags_o;
  logic           clock_halt_o, done_o;
  ocd_result_type result_o;
  int             fail_count = 0, checks = 0;
  localparam logic [7:0] PROG [0:27] = '{8'h3D, 8'h80, 8'h4D, 8'h5D, 8'h6D, 8'h10, 8'h7D, 8'h9F,
    8'hC6, 8'h12, 8'h34, 8'hD6, 8'h01, 8'h02, 8'hE6, 8'h05, 8'hF6, 8'h20, 8'h00, 8'h01, 8'h40,
    8'h02, 8'h00, 8'h40, 8'h02, 8'h8F, 8'h9D, 8'h8F};
  // 20 MHz clock.
  always #25 clk_i = !clk_i;
  ocd_decoder i_dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .mem_data_i(mem_data_i), .mem_valid_i(mem_valid_i),
    .mem_ready_o(mem_ready_o), .pc_o(pc_o), .data_byte_i(data_byte_i), .irq_i(irq_i),
    .branch_cond_i(branch_cond_i), .acc_o(acc_o), .index_o(index_o), .flags_o(flags_o),
    .clock_halt_o(clock_halt_o), .result_o(result_o), .done_o(done_o));
  ocd_prog_mem i_mem (.clk_i(clk_i), .pc_i(pc_o), .stall_i(stall), .data_o(mem_data_i), .valid_o(mem_valid_i));
  // Compare one value and count it.
  task check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Print counts and verdict, then stop.
  task conclude();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // One instruction: cycle count 0 skips timing, flags 1F skip, top bits of ea and bt enable checks.
  task step(input int cyc, input logic [7:0] db, input logic bc, input logic [4:0] fl,
            input logic [16:0] ea, input logic [17:0] bt);
    int n;
    data_byte_i <= db;
    branch_cond_i <= bc;
    stall <= (cyc == 0) && ea[16];
    n = 0;
    do begin
      @(negedge clk_i);
      n++;
    end while (done_o !== 1'b1 && n < 60);
    check(16'(done_o), 16'h0001);
    if (cyc != 0) check(16'(n), 16'(cyc));
    if (fl != 5'h1F) check(16'(flags_o), 16'(fl));
    if (ea[16]) check(result_o.eff_addr, ea[15:0]);
    if (bt[17]) check(16'(result_o.branch_taken), 16'(bt[16]));
    if (bt[16]) check(result_o.branch_target, bt[15:0]);
    $display("test of opcode %h ended at %0t", result_o.opcode, $time);
    @(posedge clk_i);
  endtask
  // Cuts a hang short.
  initial begin
    #30000;
    fail_count++;
    conclude();
  end
  // Main sequence: one program covering every mode except MODE_LITERAL, then wait and wake.
  initial begin
    for (int i = 0; i < 256; i++) i_mem.mem[i] = (i < 28) ? PROG[i] : 8'h9D;
    repeat (8) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    step(0, 8'h80, 1'b0, 5'h0C, 17'h10080, 18'h0);
    step(3, 8'h00, 1'b0, 5'h0A, 17'h0, 18'h0);
    step(3, 8'h00, 1'b0, 5'h0A, 17'h0, 18'h0);
    step(5, 8'h00, 1'b0, 5'h0A, 17'h10010, 18'h0);
    step(4, 8'hFF, 1'b0, 5'h0C, 17'h10000, 18'h0);
    step(2, 8'h00, 1'b0, 5'h0C, 17'h0, 18'h0);
    step(0, 8'h00, 1'b0, 5'h1F, 17'h11234, 18'h0);
    step(0, 8'h00, 1'b0, 5'h1F, 17'h10102, 18'h0);
    step(0, 8'h00, 1'b0, 5'h1F, 17'h10005, 18'h0);
    step(0, 8'h00, 1'b0, 5'h1F, 17'h10000, 18'h0);
    step(0, 8'h00, 1'b1, 5'h1F, 17'h0, 18'h30013);
    step(0, 8'h01, 1'b0, 5'h1F, 17'h0, 18'h20000);
    step(0, 8'h01, 1'b0, 5'h1F, 17'h0, 18'h3001B);
    step(2, 8'h00, 1'b0, 5'h1F, 17'h0, 18'h0);
    repeat (4) @(negedge clk_i);
    check(16'(flags_o[FLG_I]), 16'h0000);
    check(16'(clock_halt_o), 16'h0001);
    check(16'(mem_ready_o), 16'h0000);
    check(pc_o, 16'h001A);
    check(16'(result_o.opcode), 16'(OP_WAIT_INT));
    @(posedge clk_i);
    irq_i <= 1'b1;
    repeat (4) @(negedge clk_i);
    check(16'(clock_halt_o), 16'h0000);
    @(posedge clk_i);
    irq_i <= 1'b0;
    repeat (6) @(posedge clk_i);
    conclude();
  end
endmodule
